// ---- logic/ctrl_link_if.sv ----
// Control link between the host controller and the encoder register bank
`timescale 1ns/100ps
interface ctrl_link_if;
    logic [7:0] sub_addr; // Register sub-address
    logic [7:0] wdata; // Write data
    logic wr; // One-cycle write strobe
    logic rd; // One-cycle read strobe
    logic [7:0] rdata; // Read data, valid the cycle after rd
    // Encoder end
    modport device (input sub_addr, input wdata, input wr, input rd, output rdata);
    // Host controller end
    modport host (output sub_addr, output wdata, output wr, output rd, input rdata);
endinterface

// ---- logic/encoder_ctrl_pkg.sv ----
// Shared constants and types for the encoder control register logic
package encoder_ctrl_pkg;
    // Register sub-addresses on the control link
    localparam logic [7:0] OUTPUT_POWER_CONTROL_ADDR = 8'h04;
    localparam logic [7:0] TIMING_MODE_CONTROL_ADDR = 8'h07;
    // Reset values of the two registers
    localparam logic [7:0] OUTPUT_POWER_CONTROL_RST = 8'h00;
    localparam logic [7:0] TIMING_MODE_CONTROL_RST = 8'h00;
    // Read answer for an unmapped sub-address
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
    // Output/power control field positions
    localparam int OUTPUT_FORMAT_SELECT_BIT = 0;
    localparam int COMPONENT_STANDARD_SELECT_BIT = 1;
    localparam int RGB_SYNC_INSERT_BIT = 2;
    localparam int THREE_LINE_VSYNC_ENABLE_BIT = 3;
    localparam int PEDESTAL_ENABLE_BIT = 4;
    localparam int BLANKING_FILTER_ENABLE_BIT = 5;
    localparam int SLEEP_ENABLE_BIT = 6;
    localparam int RESERVED_TOP_BIT = 7;
    // Timing mode control field positions
    localparam int MASTER_SLAVE_SELECT_BIT = 0;
    localparam int TIMING_MODE_FIELD_LSB = 1;
    localparam int BLANKING_INPUT_ENABLE_BIT = 3;
    localparam int LUMA_DELAY_FIELD_LSB = 4;
    localparam int PIXEL_PORT_FORMAT_BIT = 6;
    localparam int TIMING_COUNTER_RESET_BIT = 7;
    // Vertical sync length in half lines with the three-line option
    localparam logic [2:0] VSYNC_HALF_LINES_PAL = 3'h5;
    localparam logic [2:0] VSYNC_HALF_LINES_NTSC = 3'h6;
    // Luma delay step, time and cycles at the 50 MHz clock
    localparam int CLK_PERIOD_PS = 20000;
    localparam int LUMA_DELAY_STEP_PS = 74000;
    localparam int LUMA_DELAY_STEP_CYCLES =
        (LUMA_DELAY_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Host software register indices
    localparam logic [2:0] HOST_SUBADDR_IDX = 3'h0;
    localparam logic [2:0] HOST_DATA_IDX = 3'h1;
    localparam logic [2:0] HOST_COMMAND_IDX = 3'h2;
    localparam logic [2:0] HOST_STATUS_IDX = 3'h3;
    localparam logic [2:0] HOST_READ_DATA_IDX = 3'h4;
    // Host command bits
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_READ_BIT = 1;
    localparam int CMD_COUNTER_RESET_BIT = 2;
    // Converter signal selections
    typedef enum logic [2:0] {
        DAC_CVBS = 3'h0,
        DAC_LUMA = 3'h1,
        DAC_CHROMA = 3'h2,
        DAC_GREEN = 3'h3,
        DAC_BLUE = 3'h4,
        DAC_RED = 3'h5,
        DAC_PB = 3'h6,
        DAC_PR = 3'h7
    } dac_signal_e;
endpackage

// ---- logic/encoder_ctrl_regs.sv ----
// Encoder end: output/power and timing mode control registers
//
// Contract
// RQ1 - Output/power register, 8 bits at 04H
// RQ2 - Output select: composite or component
// RQ3 - Standard select gives YPbPr instead of RGB
// RQ4 - RGB sync bit embeds sync on RGB
// RQ5 - Slave vsync may last 2.5/3 lines
// RQ6 - Master vsync three lines NTSC, 2.5 PAL
// RQ7 - Pedestal on NTSC only, ignored in PAL
// RQ8 - Blanking filter outside active video when set
// RQ9 - Sleep bit set enters sleep mode
// RQ10 - Registers stay accessible during sleep
// RQ11 - Clearing sleep bit resumes normal operation
// RQ12 - External reset leaves sleep mode
// RQ13 - Host writes zero to reserved bit
// RQ14 - Timing register at 07H, read and write
// RQ15 - Master/slave bit selects timing source
// RQ16 - Two-bit timing mode field
// RQ17 - Blanking input honoured only in slave
// RQ18 - Luma delay field, 74 ns per step; code rounds each step up to 4 cycles of 20 ns, 80 ns
// RQ19 - Host writes zero to pixel format bit
// RQ20 - Low-high-low toggle resets timing counters
// RQ21 - Host toggles after power-up, reset, mode change
// RQ22 - All selects set, chroma clear: Y, Pb, Pr
// RQ23 - Registers kept across sleep entry and exit
`timescale 1ns/100ps
module encoder_ctrl_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control link
    ctrl_link_if.device link,
    // Settings held in other registers of the encoder
    input wire logic pal_mode,
    input wire logic output_swap_select,
    input wire logic extra_chroma_select,
    // External blanking pin, active low
    input wire logic blank_in_n,
    // Converter routing
    output encoder_ctrl_pkg::dac_signal_e dac_a_sel,
    output encoder_ctrl_pkg::dac_signal_e dac_b_sel,
    output encoder_ctrl_pkg::dac_signal_e dac_c_sel,
    output logic sync_on_rgb,
    // Timing generator control
    output logic master_mode,
    output logic [1:0] timing_mode,
    output logic [2:0] master_vsync_half_lines,
    output logic timing_counter_clear,
    output logic [7:0] luma_delay_cycles,
    // Analog and filter control
    output logic pedestal_active,
    output logic blank_filter_on,
    output logic sleep_active,
    // Blanking seen by the datapath, active low
    output logic blank_out_n
);
    import encoder_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    ////////////////////////////////////////////////////////////////////////

    // Output/power control register
    logic [7:0] output_power_control_r;
    // Timing mode control register
    logic [7:0] timing_mode_control_r;
    // Read data register
    logic [7:0] rdata_r;
    // Previous timing counter reset bit, for the toggle detector
    logic counter_reset_prev_r;
    // Blanking pin synchroniser
    logic blank_meta_r;
    logic blank_sync_r;

    // Field views of the registers
    wire logic output_format_select = output_power_control_r[OUTPUT_FORMAT_SELECT_BIT];
    wire logic component_standard_select = output_power_control_r[COMPONENT_STANDARD_SELECT_BIT];
    wire logic rgb_sync_insert = output_power_control_r[RGB_SYNC_INSERT_BIT];
    wire logic three_line_vsync_enable = output_power_control_r[THREE_LINE_VSYNC_ENABLE_BIT];
    wire logic pedestal_enable = output_power_control_r[PEDESTAL_ENABLE_BIT];
    wire logic blanking_filter_enable = output_power_control_r[BLANKING_FILTER_ENABLE_BIT];
    wire logic sleep_enable = output_power_control_r[SLEEP_ENABLE_BIT];
    wire logic master_slave_select = timing_mode_control_r[MASTER_SLAVE_SELECT_BIT];
    wire logic [1:0] timing_mode_field = timing_mode_control_r[TIMING_MODE_FIELD_LSB +: 2];
    wire logic blanking_input_enable = timing_mode_control_r[BLANKING_INPUT_ENABLE_BIT];
    wire logic [1:0] luma_delay_field = timing_mode_control_r[LUMA_DELAY_FIELD_LSB +: 2];
    wire logic timing_counter_reset = timing_mode_control_r[TIMING_COUNTER_RESET_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Register writes and reads
    ////////////////////////////////////////////////////////////////////////

    // Output/power register; writes taken in sleep too, never cleared by sleep
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // External reset also drops the sleep bit
            output_power_control_r <= OUTPUT_POWER_CONTROL_RST; // RQ12
        end else if (link.wr && link.sub_addr == OUTPUT_POWER_CONTROL_ADDR) begin
            // Every bit stored as written
            output_power_control_r <= link.wdata; // RQ1 RQ10 RQ23
        end
    end

    // Timing mode control register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            timing_mode_control_r <= TIMING_MODE_CONTROL_RST;
        end else if (link.wr && link.sub_addr == TIMING_MODE_CONTROL_ADDR) begin
            // Whole byte stored, pixel format bit kept as written
            timing_mode_control_r <= link.wdata; // RQ14
        end
    end

    // Read data stands the cycle after the read strobe, also during sleep
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_r <= UNMAPPED_READ_VALUE;
        end else if (link.rd) begin
            case (link.sub_addr)
                OUTPUT_POWER_CONTROL_ADDR: begin
                    rdata_r <= output_power_control_r; // RQ1 RQ10
                end
                TIMING_MODE_CONTROL_ADDR: begin
                    rdata_r <= timing_mode_control_r; // RQ14
                end
                default: begin
                    // Unmapped sub-address reads as zero
                    rdata_r <= UNMAPPED_READ_VALUE;
                end
            endcase
        end
    end

    assign link.rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Converter routing
    ////////////////////////////////////////////////////////////////////////

    // Routing of the three converters from the select bits
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dac_a_sel <= DAC_CVBS;
            dac_b_sel <= DAC_CVBS;
            dac_c_sel <= DAC_CHROMA;
        end else begin
            // Converter A: luma or green when swapped, else composite or chroma
            if (output_swap_select) begin
                if (output_format_select && !component_standard_select) begin
                    dac_a_sel <= DAC_GREEN; // RQ2
                end else begin
                    dac_a_sel <= DAC_LUMA; // RQ22
                end
            end else if (extra_chroma_select) begin
                dac_a_sel <= DAC_CHROMA;
            end else begin
                dac_a_sel <= DAC_CVBS;
            end
            // Converters B and C: component pair or composite with chroma
            if (output_format_select) begin
                if (component_standard_select) begin
                    dac_b_sel <= DAC_PB; // RQ3 RQ22
                    dac_c_sel <= DAC_PR; // RQ3 RQ22
                end else begin
                    dac_b_sel <= DAC_BLUE; // RQ2
                    dac_c_sel <= DAC_RED; // RQ2
                end
            end else begin
                dac_b_sel <= DAC_CVBS; // RQ2
                dac_c_sel <= DAC_CHROMA; // RQ2
            end
        end
    end

    // Sync embedded on the component outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_on_rgb <= 1'b0;
        end else begin
            sync_on_rgb <= rgb_sync_insert; // RQ4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timing generator control
    ////////////////////////////////////////////////////////////////////////

    // Timing source, mode and master vsync length
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            master_mode <= 1'b0;
            timing_mode <= 2'h0;
            master_vsync_half_lines <= 3'h0;
        end else begin
            master_mode <= master_slave_select; // RQ15
            timing_mode <= timing_mode_field; // RQ16
            if (master_slave_select && three_line_vsync_enable) begin
                // Zero means the standard vsync of the timing mode
                master_vsync_half_lines <= pal_mode ? VSYNC_HALF_LINES_PAL
                                                    : VSYNC_HALF_LINES_NTSC; // RQ6
            end else begin
                master_vsync_half_lines <= 3'h0;
            end
        end
    end

    // Low-high-low toggle: the falling edge finishes it, one-cycle clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            counter_reset_prev_r <= 1'b0;
            timing_counter_clear <= 1'b0;
        end else begin
            counter_reset_prev_r <= timing_counter_reset;
            timing_counter_clear <= counter_reset_prev_r && !timing_counter_reset; // RQ20
        end
    end

    // Luma delay in clock cycles, one step per field count
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            luma_delay_cycles <= 8'h00;
        end else begin
            luma_delay_cycles <= 8'(int'(luma_delay_field) * LUMA_DELAY_STEP_CYCLES); // RQ18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog, filter and blanking control
    ////////////////////////////////////////////////////////////////////////

    // Pedestal only in NTSC, filter and sleep straight from their bits
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pedestal_active <= 1'b0;
            blank_filter_on <= 1'b0;
            sleep_active <= 1'b0;
        end else begin
            pedestal_active <= pedestal_enable && !pal_mode; // RQ7
            blank_filter_on <= blanking_filter_enable; // RQ8
            // Follows the bit both ways, so clearing it wakes the encoder
            sleep_active <= sleep_enable; // RQ9 RQ11
        end
    end

    // Two-stage synchroniser on the blanking pin
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            blank_meta_r <= 1'b1;
            blank_sync_r <= 1'b1;
        end else begin
            blank_meta_r <= blank_in_n;
            blank_sync_r <= blank_meta_r;
        end
    end

    // Pin honoured only when enabled and the encoder is a timing slave
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            blank_out_n <= 1'b1;
        end else if (blanking_input_enable && !master_slave_select) begin
            blank_out_n <= blank_sync_r; // RQ17
        end else begin
            blank_out_n <= 1'b1;
        end
    end
endmodule

// ---- logic/encoder_host_ctrl.sv ----
// Host end: software command port driving the encoder control link
`timescale 1ns/100ps
module encoder_host_ctrl
    import encoder_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Software register port
    input wire logic [2:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [7:0] sw_rdata,
    // Control link
    ctrl_link_if.host link
);
    import encoder_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State and registers
    ////////////////////////////////////////////////////////////////////////

    // Link sequencer states
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_READ = 6'h02,
        S_CAPTURE = 6'h04,
        S_TOG_READ = 6'h08,
        S_TOG_CAPTURE = 6'h10,
        S_TOG_HIGH = 6'h20
    } host_state_e;

    host_state_e state_r; // Sequencer state
    logic [7:0] subaddr_r; // Target sub-address
    logic [7:0] data_r; // Data to write
    logic [7:0] read_data_r; // Last data read back
    logic done_r; // Sticky completion flag
    logic [7:0] tog_base_r; // Timing register image for the toggle
    logic [7:0] link_addr_r; // Link drive registers
    logic [7:0] link_wdata_r;
    logic link_wr_r;
    logic link_rd_r;
    logic busy; // Sequence in progress
    logic [7:0] write_value; // Write data with must-be-zero bits cleared

    assign busy = (state_r != S_IDLE);
    assign link.sub_addr = link_addr_r;
    assign link.wdata = link_wdata_r;
    assign link.wr = link_wr_r;
    assign link.rd = link_rd_r;

    // Must-be-zero bits forced low before they reach the encoder
    always_comb begin
        write_value = data_r;
        if (subaddr_r == OUTPUT_POWER_CONTROL_ADDR) begin
            write_value[RESERVED_TOP_BIT] = 1'b0; // RQ13
        end
        if (subaddr_r == TIMING_MODE_CONTROL_ADDR) begin
            write_value[PIXEL_PORT_FORMAT_BIT] = 1'b0; // RQ19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    ////////////////////////////////////////////////////////////////////////

    // Sub-address and data set up by software
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            subaddr_r <= 8'h00;
            data_r <= 8'h00;
        end else if (sw_wr && !busy) begin
            if (sw_addr == HOST_SUBADDR_IDX) begin
                subaddr_r <= sw_wdata;
            end
            if (sw_addr == HOST_DATA_IDX) begin
                data_r <= sw_wdata;
            end
        end
    end

    // Read port, data in the cycle after the strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sw_rdata <= 8'h00;
        end else if (sw_rd) begin
            case (sw_addr)
                HOST_SUBADDR_IDX: sw_rdata <= subaddr_r;
                HOST_DATA_IDX: sw_rdata <= data_r;
                HOST_STATUS_IDX: sw_rdata <= {6'h00, done_r, busy};
                HOST_READ_DATA_IDX: sw_rdata <= read_data_r;
                default: sw_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link sequencer
    ////////////////////////////////////////////////////////////////////////

    // Commands launch link cycles; toggle does read, then writes 0, 1, 0
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= S_IDLE;
            link_addr_r <= 8'h00;
            link_wdata_r <= 8'h00;
            link_wr_r <= 1'b0;
            link_rd_r <= 1'b0;
            read_data_r <= 8'h00;
            tog_base_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            link_wr_r <= 1'b0;
            link_rd_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (sw_wr && sw_addr == HOST_COMMAND_IDX) begin
                        done_r <= 1'b0;
                        if (sw_wdata[CMD_WRITE_BIT]) begin
                            link_addr_r <= subaddr_r;
                            link_wdata_r <= write_value;
                            link_wr_r <= 1'b1;
                            done_r <= 1'b1;
                        end else if (sw_wdata[CMD_READ_BIT]) begin
                            link_addr_r <= subaddr_r;
                            link_rd_r <= 1'b1;
                            state_r <= S_READ;
                        end else if (sw_wdata[CMD_COUNTER_RESET_BIT]) begin
                            link_addr_r <= TIMING_MODE_CONTROL_ADDR;
                            link_rd_r <= 1'b1;
                            state_r <= S_TOG_READ;
                        end
                    end
                end
                S_READ: begin
                    state_r <= S_CAPTURE;
                end
                S_CAPTURE: begin
                    read_data_r <= link.rdata;
                    done_r <= 1'b1;
                    state_r <= S_IDLE;
                end
                S_TOG_READ: begin
                    state_r <= S_TOG_CAPTURE;
                end
                S_TOG_CAPTURE: begin
                    // First write: counter reset bit low
                    tog_base_r <= link.rdata;
                    link_wdata_r <= {1'b0, 1'b0, link.rdata[5:0]}; // RQ19 RQ21
                    link_wr_r <= 1'b1;
                    state_r <= S_TOG_HIGH;
                end
                S_TOG_HIGH: begin
                    // Second write high, third low on the way back
                    if (link_wdata_r[TIMING_COUNTER_RESET_BIT]) begin
                        link_wdata_r <= {1'b0, 1'b0, tog_base_r[5:0]}; // RQ21
                        link_wr_r <= 1'b1;
                        done_r <= 1'b1;
                        state_r <= S_IDLE;
                    end else begin
                        link_wdata_r <= {1'b1, 1'b0, tog_base_r[5:0]}; // RQ21
                        link_wr_r <= 1'b1;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- tb/encoder_ctrl_chk.sv ----
// Checker watching the control link between host and encoder ends
`timescale 1ns/100ps
module encoder_ctrl_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link signals
    input wire logic [7:0] sub_addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata
);
    logic [7:0] pwr_r; // Last byte written at 04
    logic [7:0] tim_r; // Last byte written at 07
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow copies of both registers, fed by link writes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pwr_r <= 8'h00;
            tim_r <= 8'h00;
        end else if (wr && sub_addr == 8'h04) begin
            pwr_r <= wdata;
        end else if (wr && sub_addr == 8'h07) begin
            tim_r <= wdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_one_strobe; !(wr && rd); endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("wr and rd high together");
    property p_pwr_top; wr && sub_addr == 8'h04 |-> !wdata[7]; endproperty
    a_pwr_top: assert property (p_pwr_top) else $error("top bit written as one");
    property p_pix_fmt; wr && sub_addr == 8'h07 |-> !wdata[6]; endproperty
    a_pix_fmt: assert property (p_pix_fmt) else $error("pixel format bit set");
    property p_rd_pwr; rd && sub_addr == 8'h04 |=> rdata == $past(pwr_r); endproperty
    a_rd_pwr: assert property (p_rd_pwr) else $error("output power readback wrong");
    property p_rd_tim; rd && sub_addr == 8'h07 |=> rdata == $past(tim_r); endproperty
    a_rd_tim: assert property (p_rd_tim) else $error("timing readback wrong");
    property p_rd_none; rd && sub_addr != 8'h04 && sub_addr != 8'h07 |=> rdata == 8'h00;
    endproperty
    a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");
    property p_hold; !rd |=> $stable(rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_toggle; wr && sub_addr == 8'h07 && wdata[7] |=>
        wr && sub_addr == 8'h07 && !wdata[7]; endproperty
    a_toggle: assert property (p_toggle) else $error("counter reset bit left high");
endmodule

// ---- tb/testbench.sv ----
// Testbench joining the host and encoder ends over the control link
`timescale 1ns/100ps
module testbench;
    import encoder_ctrl_pkg::*;
    logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0; // Clock, reset, strobes
    logic pal = 1'b0, swp = 1'b0, xch = 1'b0, bin_n = 1'b1; // Encoder side inputs
    logic [2:0] ad = 3'h0;
    logic [7:0] wd = 8'h00, sd, rv;
    dac_signal_e da, db, dc;
    logic sor, mm, tcc, pa, bf, sl, bo_n; // Encoder outputs
    logic [1:0] tm;
    logic [2:0] vh;
    logic [7:0] ld;
    int error_cnt = 0, cmp_count = 0, clr_n = 0;
    ctrl_link_if link();
    encoder_host_ctrl u_encoder_host_ctrl (.clk(clk), .reset(reset), .sw_addr(ad), .sw_wdata(wd),
        .sw_wr(wr), .sw_rd(rd), .sw_rdata(sd), .link(link));
    encoder_ctrl_regs u_encoder_ctrl_regs (.clk(clk), .reset(reset), .link(link), .pal_mode(pal),
        .output_swap_select(swp), .extra_chroma_select(xch), .blank_in_n(bin_n), .dac_a_sel(da),
        .dac_b_sel(db), .dac_c_sel(dc), .sync_on_rgb(sor), .master_mode(mm), .timing_mode(tm),
        .master_vsync_half_lines(vh), .timing_counter_clear(tcc), .luma_delay_cycles(ld),
        .pedestal_active(pa), .blank_filter_on(bf), .sleep_active(sl), .blank_out_n(bo_n));
    encoder_ctrl_chk u_encoder_ctrl_chk (.clk(clk), .reset(reset), .sub_addr(link.sub_addr),
        .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
    ////////////////////////////////////////////////////////////////////////////////
    always #10 clk = ~clk;
    // Count counter-clear pulses
    always @(posedge clk) if (tcc === 1'b1) clr_n++;
    task automatic complete_run();
        $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One software port access, a cycle of gap after it
    task automatic sw(input logic [2:0] a, input logic [7:0] d, input logic w, output logic [7:0] v);
        ad <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 v = sd;
        @(posedge clk);
    endtask
    // Link command through the host: address, data, command, wait done, fetch data
    task automatic lop(input logic [7:0] a, input logic [7:0] d, input logic [2:0] c);
        int n = 0;
        sw(3'h0, a, 1'b1, rv);
        sw(3'h1, d, 1'b1, rv);
        sw(3'h2, {5'h00, c}, 1'b1, rv);
        do begin
            sw(3'h3, 8'h00, 1'b0, rv);
            n++;
        end while (rv[1] !== 1'b1 && n < 20);
        if (rv[1] !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
        sw(3'h4, 8'h00, 1'b0, rv);
    endtask
    function automatic logic [8:0] dac_exp(input logic f, input logic s, input logic w,
        input logic x);
        dac_signal_e a, b, c;
        a = w ? ((f && !s) ? DAC_GREEN : DAC_LUMA) : (x ? DAC_CHROMA : DAC_CVBS);
        b = f ? (s ? DAC_PB : DAC_BLUE) : DAC_CVBS;
        c = f ? (s ? DAC_PR : DAC_RED) : DAC_CHROMA;
        return {a, b, c};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        lop(8'h04, 8'h00, 3'h2);
        chk("pwr reset", rv, 8'h00);
        lop(8'h07, 8'h00, 3'h2);
        chk("tim reset", rv, 8'h00);
        lop(8'h05, 8'h00, 3'h2);
        chk("unmapped", rv, 8'h00);
        lop(8'h04, 8'hff, 3'h1);
        lop(8'h04, 8'h00, 3'h2);
        chk("pwr all", rv, 8'h7f);
        chk("sleep", sl, 1);
        chk("blank filter", bf, 1);
        chk("sync rgb", sor, 1);
        chk("pedestal ntsc", pa, 1);
        $display("Test output power done");
        bin_n <= 1'b0;
        lop(8'h07, 8'h7f, 3'h1);
        lop(8'h07, 8'h00, 3'h2);
        chk("tim in sleep", rv, 8'h3f);
        chk("master", mm, 1);
        chk("mode", tm, 3);
        chk("luma", ld, 12);
        chk("vsync ntsc", vh, 6);
        chk("blank master", bo_n, 1);
        pal <= 1'b1;
        repeat (3) @(posedge clk);
        chk("pedestal pal", pa, 0);
        chk("vsync pal", vh, 5);
        lop(8'h04, 8'h3f, 3'h1);
        chk("wake", sl, 0);
        lop(8'h07, 8'h00, 3'h2);
        chk("kept", rv, 8'h3f);
        lop(8'h07, 8'h08, 3'h1);
        repeat (4) @(posedge clk);
        chk("blank slave", bo_n, 0);
        chk("vsync slave", vh, 0);
        $display("Test timing done");
        clr_n = 0;
        lop(8'h00, 8'h00, 3'h4);
        chk("clear pulses", clr_n, 1);
        $display("Test counter reset done");
        for (int m = 0; m < 16; m++) begin
            if (m % 4 == 0) lop(8'h04, {6'h00, m[3:2]}, 3'h1);
            swp <= m[0];
            xch <= m[1];
            repeat (3) @(posedge clk);
            chk("dac", {da, db, dc}, dac_exp(m[2], m[3], m[0], m[1]));
            chk("flags off", {sor, bf, sl, mm, tm}, 0);
        end
        $display("Test converter routing done");
        lop(8'h04, 8'h40, 3'h1);
        chk("sleep again", sl, 1);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset wake", sl, 0);
        $display("Test reset in sleep done");
        complete_run();
    end
endmodule
